// ### core/uda_top.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// shared constants and types
// ****************************************************************
package uda_pkg;
   localparam int CLK_HZ     = 20_000_000;
   localparam int BAUD_HZ    = 9600;
   localparam int OVERSAMPLE = 16;
   localparam logic [7:0] OS_DIV = 8'(CLK_HZ / (BAUD_HZ * OVERSAMPLE));
   localparam logic [3:0] OS_LAST = 4'(OVERSAMPLE - 1);
   localparam logic [3:0] OS_MID  = 4'(OVERSAMPLE / 2 - 1);
   // register selects
   localparam logic [1:0] RS_DATA    = 2'h0;
   localparam logic [1:0] RS_STATUS  = 2'h1;
   localparam logic [1:0] RS_COMMAND = 2'h2;
   localparam logic [1:0] RS_CONTROL = 2'h3;
   // control fields: word length code 0..3 means 8..5 bits
   localparam int CTL_WLEN_LSB = 5;
   localparam int CTL_STOP2    = 7;
   // command fields
   localparam int CMD_PAR_EN   = 5;
   localparam int CMD_PAR_EVEN = 6;
   // status bits
   localparam int ST_PERR = 0;
   localparam int ST_FERR = 1;
   localparam int ST_OVR  = 2;
   localparam int ST_RDRF = 3;
   localparam int ST_TDRE = 4;
   // reset values and sizes
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [7:0] CMD_RST = 8'h00;
   localparam int DATA_W        = 8;
   localparam int TX_FIFO_DEPTH = 8;

   typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} uda_st_t;

   typedef struct packed {
      logic       cs0;
      logic       cs1_n;
      logic       rw;
      logic [1:0] rs;
      logic [7:0] data;
      logic       strobe;
   } uda_bus_t;

   typedef struct packed {
      uda_st_t    st;
      logic [3:0] os;
      logic [2:0] idx;
      logic       par;
      logic       stop2nd;
      logic [7:0] shift;
      logic       line;
   } uda_ser_t;
endpackage : uda_pkg

// ****************************************************************
// serial interface core
// ****************************************************************
module uda_top
   import uda_pkg::*;
(
   // clock and reset
   input  wire logic       CLK_SYS_I,
   input  wire logic       RESETN_I,
   // processor bus
   input  wire logic       CS0_I,
   input  wire logic       CS1_N_I,
   input  wire logic       RW_I,
   input  wire logic [1:0] RS_I,
   input  wire logic       STROBE_I,
   input  wire logic [7:0] DATA_I,
   output logic      [7:0] DATA_O,
   output logic            DATA_OE_O,
   // serial lines
   input  wire logic       RXD_I,
   output logic            TXD_O
);
   uda_bus_t   bus_m;
   uda_bus_t   bus_s;
   logic       strobe_d;
   logic       rxd_m;
   logic       rxd_s;
   logic [7:0] os_cnt;
   logic       os_tick;
   logic       access;
   logic       sel;
   logic       wr_tx;
   logic       rd_rx;
   logic [7:0] ctl;
   logic [7:0] cmd;
   logic [7:0] rx_hold;
   logic       rdrf;
   logic       perr;
   logic       ferr;
   logic       ovr;
   logic [7:0] next_ctl;
   logic [7:0] next_cmd;
   logic [7:0] next_rx_hold;
   logic       next_rdrf;
   logic       next_perr;
   logic       next_ferr;
   logic       next_ovr;
   logic [7:0] next_data_o;
   logic [1:0] wcode;
   logic [2:0] last_idx;
   logic [7:0] wmask;
   logic       tdre;
   logic       fifo_valid;
   logic [7:0] fifo_data;
   logic       tx_pop;
   uda_ser_t   tx;
   uda_ser_t   next_tx;
   uda_ser_t   rx;
   uda_ser_t   next_rx;
   logic       rx_done;
   logic       rx_perr;
   logic       rx_ferr;
   logic       rx_accept;
   logic       tx_p;
   logic       rx_p;

   // ****************************************************************
   // pin synchronisers and bus decode
   // ****************************************************************
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         bus_m    <= '0;
         bus_s    <= '0;
         strobe_d <= 1'b0;
         rxd_m    <= 1'b1;
         rxd_s    <= 1'b1;
      end else begin
         bus_m    <= '{CS0_I, CS1_N_I, RW_I, RS_I, DATA_I, STROBE_I};
         bus_s    <= bus_m;
         strobe_d <= bus_s.strobe;
         rxd_m    <= RXD_I;
         rxd_s    <= rxd_m;
      end
   end

   assign sel       = bus_s.cs0 & ~bus_s.cs1_n;
   // one action per strobe, taken on its leading edge
   assign access    = sel & bus_s.strobe & ~strobe_d;
   assign wr_tx     = access & ~bus_s.rw & (bus_s.rs == RS_DATA);
   assign rd_rx     = access & bus_s.rw & (bus_s.rs == RS_DATA);
   assign DATA_OE_O = sel & bus_s.strobe & bus_s.rw;

   assign wcode    = ctl[CTL_WLEN_LSB +: 2];
   assign last_idx = 3'h7 - {1'b0, wcode};
   assign wmask    = 8'hFF >> wcode;

   // ****************************************************************
   // oversample tick
   // ****************************************************************
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         os_cnt <= 8'h00;
      end else begin
         os_cnt <= os_tick ? 8'h00 : 8'(os_cnt + 8'h01);
      end
   end
   assign os_tick = (os_cnt == OS_DIV - 8'h01);

   // ****************************************************************
   // registers
   // ****************************************************************
   always_comb begin
      next_ctl     = ctl;
      next_cmd     = cmd;
      next_rx_hold = rx_hold;
      next_rdrf    = rdrf;
      next_perr    = perr;
      next_ferr    = ferr;
      next_ovr     = ovr;
      next_data_o  = DATA_O;
      if (access && !bus_s.rw) begin
         if (bus_s.rs == RS_STATUS) begin
            next_ovr = 1'b0;
         end else if (bus_s.rs == RS_COMMAND) begin
            next_cmd = bus_s.data;
         end else if (bus_s.rs == RS_CONTROL) begin
            next_ctl = bus_s.data;
         end
      end
      if (access && bus_s.rw) begin
         if (bus_s.rs == RS_DATA) begin
            next_data_o = rx_hold;
            next_rdrf   = 1'b0;
         end else if (bus_s.rs == RS_STATUS) begin
            next_data_o = {3'h0, tdre, rdrf, ovr, ferr, perr};
         end else if (bus_s.rs == RS_COMMAND) begin
            next_data_o = cmd;
         end else begin
            next_data_o = ctl;
         end
      end
      // a character lost in the cycle of a status write still wins the flag
      if (rx_done && !rx_accept) begin
         next_ovr = 1'b1;
      end
      if (rx_accept) begin
         next_rx_hold = rx.shift & wmask;
         next_rdrf    = 1'b1;
         next_perr    = rx_perr;
         next_ferr    = rx_ferr;
         next_ovr     = 1'b0;
      end
   end

   // old data is kept on overrun, so software sees the oldest character
   assign rx_accept = rx_done & (~rdrf | rd_rx);

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         ctl     <= CTL_RST;
         cmd     <= CMD_RST;
         rx_hold <= 8'h00;
         rdrf    <= 1'b0;
         perr    <= 1'b0;
         ferr    <= 1'b0;
         ovr     <= 1'b0;
         DATA_O  <= 8'h00;
      end else begin
         ctl     <= next_ctl;
         cmd     <= next_cmd;
         rx_hold <= next_rx_hold;
         rdrf    <= next_rdrf;
         perr    <= next_perr;
         ferr    <= next_ferr;
         ovr     <= next_ovr;
         DATA_O  <= next_data_o;
      end
   end

   // ****************************************************************
   // transmitter
   // ****************************************************************
   uda_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (TX_FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_i       (CLK_SYS_I),
      .resetn_i    (RESETN_I),
      .in_valid_i  (wr_tx),
      .in_data_i   (bus_s.data),
      .in_ready_o  (tdre),
      .out_valid_o (fifo_valid),
      .out_data_o  (fifo_data),
      .out_ready_i (tx_pop)
   );

   assign tx_p = tx.par ^ tx.shift[tx.idx];

   always_comb begin
      next_tx = tx;
      tx_pop  = 1'b0;
      if (os_tick) begin
         next_tx.os = 4'(tx.os + 4'h1);
         case (tx.st)
            S_IDLE: begin
               next_tx.os = 4'h0;
               if (fifo_valid) begin
                  tx_pop          = 1'b1;
                  next_tx.shift   = fifo_data;
                  next_tx.par     = 1'b0;
                  next_tx.stop2nd = 1'b0;
                  next_tx.st      = S_START;
                  next_tx.line    = 1'b0;
               end
            end
            S_START: begin
               if (tx.os == OS_LAST) begin
                  next_tx.st   = S_DATA;
                  next_tx.idx  = 3'h0;
                  next_tx.line = tx.shift[0];
               end
            end
            S_DATA: begin
               if (tx.os == OS_LAST) begin
                  next_tx.par = tx_p;
                  if (tx.idx == last_idx) begin
                     if (cmd[CMD_PAR_EN]) begin
                        next_tx.st   = S_PAR;
                        next_tx.line = cmd[CMD_PAR_EVEN] ? tx_p : ~tx_p;
                     end else begin
                        next_tx.st   = S_STOP;
                        next_tx.line = 1'b1;
                     end
                  end else begin
                     next_tx.idx  = 3'(tx.idx + 3'h1);
                     next_tx.line = tx.shift[3'(tx.idx + 3'h1)];
                  end
               end
            end
            S_PAR: begin
               if (tx.os == OS_LAST) begin
                  next_tx.st   = S_STOP;
                  next_tx.line = 1'b1;
               end
            end
            default: begin
               if (tx.os == OS_LAST) begin
                  if (ctl[CTL_STOP2] && !tx.stop2nd) begin
                     next_tx.stop2nd = 1'b1;
                  end else begin
                     next_tx.st = S_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         tx      <= '0;
         tx.line <= 1'b1;
      end else begin
         tx <= next_tx;
      end
   end
   assign TXD_O = tx.line;

   // ****************************************************************
   // receiver
   // ****************************************************************
   assign rx_p = rx.par ^ rxd_s;

   always_comb begin
      next_rx = rx;
      rx_done = 1'b0;
      rx_perr = rx.line;
      rx_ferr = ~rxd_s;
      if (os_tick) begin
         next_rx.os = 4'(rx.os + 4'h1);
         case (rx.st)
            S_IDLE: begin
               next_rx.os = 4'h0;
               if (!rxd_s) begin
                  next_rx.st = S_START;
               end
            end
            S_START: begin
               // recheck at mid bit so a glitch is not taken for a start
               if (rx.os == OS_MID) begin
                  next_rx.os    = 4'h0;
                  next_rx.st    = rxd_s ? S_IDLE : S_DATA;
                  next_rx.idx   = 3'h0;
                  next_rx.par   = 1'b0;
                  next_rx.line  = 1'b0;
                  next_rx.shift = 8'h00;
               end
            end
            S_DATA: begin
               if (rx.os == OS_LAST) begin
                  next_rx.shift[rx.idx] = rxd_s;
                  next_rx.par           = rx_p;
                  next_rx.idx           = 3'(rx.idx + 3'h1);
                  if (rx.idx == last_idx) begin
                     next_rx.st = cmd[CMD_PAR_EN] ? S_PAR : S_STOP;
                  end
               end
            end
            S_PAR: begin
               if (rx.os == OS_LAST) begin
                  next_rx.line = cmd[CMD_PAR_EVEN] ? rx_p : ~rx_p;
                  next_rx.st   = S_STOP;
               end
            end
            default: begin
               if (rx.os == OS_LAST) begin
                  rx_done    = 1'b1;
                  next_rx.st = S_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         rx <= '0;
      end else begin
         rx <= next_rx;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESETN_I);

   sequence s_tx_begin;
      tx.st == S_IDLE ##1 tx.st == S_START;
   endsequence
   sequence s_tx_first;
      tx.st == S_START ##1 tx.st == S_DATA;
   endsequence

   a_tx_start_low : assert property (
      s_tx_begin |-> !TXD_O [*8])
      else $error("start bit not low");
   a_tx_first_bit : assert property (
      s_tx_first |-> tx.idx == 3'h0 && TXD_O == tx.shift[0])
      else $error("first data bit is not bit 0");
   a_tx_bit_order : assert property (
      (tx.st == S_DATA && $past(tx.st) == S_DATA && $changed(tx.idx))
      |-> tx.idx == 3'($past(tx.idx) + 3'h1) && TXD_O == tx.shift[tx.idx])
      else $error("data bits not ascending");
   a_tx_word_len : assert property (
      (tx.st == S_DATA && $past(tx.st) == S_DATA && $changed(tx.idx))
      |-> $past(tx.idx) != last_idx)
      else $error("bit sent past word length");
   a_tx_stop_high : assert property (
      tx.st == S_STOP || tx.st == S_IDLE |-> TXD_O)
      else $error("stop or idle line not high");
   a_tx_bit_hold : assert property (
      !os_tick |=> $stable(TXD_O))
      else $error("line moved off a tick");
   // received bit lands at its index
   a_rx_fill_up : assert property (
      (rx.st == S_DATA && $changed(rx.idx) && $past(rx.st) == S_DATA)
      |-> rx.shift[$past(rx.idx)] == $past(rxd_s))
      else $error("received bit stored out of place");
   a_rx_high_zero : assert property (
      rx_accept |=> (rx_hold & ~wmask) == 8'h00)
      else $error("unused receive bits not zero");
   a_frame_parity : assert property (
      (rx.st == S_STOP && $past(rx.st) == S_DATA) |-> !$past(cmd[CMD_PAR_EN]))
      else $error("parity step skipped");
   a_rdrf_clear : assert property (
      rd_rx && !rx_done |=> !rdrf)
      else $error("full flag kept after read");
   a_rx_par_strip : assert property (
      (rx.st == S_PAR && os_tick && rx.os == OS_LAST) |=> $stable(rx.shift))
      else $error("parity bit stored in receive data");

endmodule : uda_top

`default_nettype wire

// ### core/uda_fifo.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// transmit staging fifo
// ****************************************************************
module uda_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   // fill side
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   // drain side
   output logic                  out_valid_o,
   output logic      [WIDTH-1:0] out_data_o,
   input  wire logic             out_ready_i
);
   // depth must be a power of two so the pointers wrap by themselves
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wp;
   logic [AW-1:0]    rp;
   logic [AW:0]      cnt;
   logic [AW-1:0]    next_wp;
   logic [AW-1:0]    next_rp;
   logic [AW:0]      next_cnt;
   logic             push;
   logic             pop;

   assign in_ready_o  = (cnt != FULL_CNT);
   assign out_valid_o = (cnt != '0);
   assign out_data_o  = mem[rp];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always_comb begin
      next_wp  = wp;
      next_rp  = rp;
      next_cnt = cnt;
      if (push) begin
         next_wp = AW'(wp + 1'b1);
      end
      if (pop) begin
         next_rp = AW'(rp + 1'b1);
      end
      if (push && !pop) begin
         next_cnt = (AW+1)'(cnt + 1'b1);
      end else if (pop && !push) begin
         next_cnt = (AW+1)'(cnt - 1'b1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         wp  <= next_wp;
         rp  <= next_rp;
         cnt <= next_cnt;
      end
   end

   // storage needs no reset, only the pointers and count do
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wp] <= in_data_i;
      end
   end

endmodule : uda_fifo

`default_nettype wire

// ### test/uda_modem_model.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// modem on the far side of the serial lines
// ****************************************************************
module uda_modem_model
   import uda_pkg::*;
#(
   parameter int BIT_NS = 104000
) (
   // serial lines
   input  wire logic txd_i,
   output var  logic rxd_o
);
   // a marking line idles high between characters
   initial rxd_o = 1'b1;

   task automatic send(input logic [7:0] d, input int nb, input logic pen,
                       input logic even, input logic two);
      logic p;
      p = ~even;
      rxd_o = 1'b0;
      #(BIT_NS);
      for (int i = 0; i < nb; i++) begin
         rxd_o = d[i];
         p = p ^ d[i];
         #(BIT_NS);
      end
      if (pen) begin
         rxd_o = p;
         #(BIT_NS);
      end
      rxd_o = 1'b1;
      #(BIT_NS * (two ? 2 : 1));
   endtask : send

   // sample each bit at its middle
   task automatic recv(input int nb, input logic pen, input logic two,
                       output logic [7:0] d, output logic par,
                       output logic ok);
      d = 8'h00;
      par = 1'b0;
      wait (txd_i === 1'b0);
      #(BIT_NS / 2);
      ok = (txd_i === 1'b0);
      for (int i = 0; i < nb; i++) begin
         #(BIT_NS);
         d[i] = txd_i;
      end
      if (pen) begin
         #(BIT_NS);
         par = txd_i;
      end
      for (int s = 0; s < (two ? 2 : 1); s++) begin
         #(BIT_NS);
         ok = ok & (txd_i === 1'b1);
      end
   endtask : recv
endmodule : uda_modem_model

`default_nettype wire

// ### test/uda_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// testbench
// ****************************************************************
module uda_top_tb_top
   import uda_pkg::*;
;
   localparam int BIT_NS = 2080 * 50;
   logic       clk_sys = 1'b0;
   logic       resetn  = 1'b0;
   logic       cs0     = 1'b0;
   logic       cs1_n   = 1'b1;
   logic       rw      = 1'b1;
   logic [1:0] rs      = 2'h0;
   logic       strobe  = 1'b0;
   logic [7:0] wdata   = 8'h00;
   logic [7:0] rdata;
   logic       data_oe;
   logic       rxd;
   logic       txd;
   int         miscompares = 0;
   int         n_compared  = 0;

   always #25 clk_sys = ~clk_sys;

   uda_top DUT (
      .CLK_SYS_I (clk_sys),
      .RESETN_I  (resetn),
      .CS0_I     (cs0),
      .CS1_N_I   (cs1_n),
      .RW_I      (rw),
      .RS_I      (rs),
      .STROBE_I  (strobe),
      .DATA_I    (wdata),
      .DATA_O    (rdata),
      .DATA_OE_O (data_oe),
      .RXD_I     (rxd),
      .TXD_O     (txd)
   );

   uda_modem_model #(.BIT_NS(BIT_NS)) modem (
      .txd_i (txd),
      .rxd_o (rxd)
   );

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // strobe held 8 clocks, low 4: inputs pass two sync flops first
   task automatic bus(input logic r, input logic [1:0] sel,
                      input logic [7:0] wd, output logic [7:0] rd);
      @(negedge clk_sys);
      cs0 = 1'b1;
      cs1_n = 1'b0;
      rw = r;
      rs = sel;
      wdata = wd;
      strobe = 1'b1;
      repeat (8) @(negedge clk_sys);
      rd = rdata;
      if (r) chk({7'h0, data_oe}, 8'h01);
      strobe = 1'b0;
      cs0 = 1'b0;
      cs1_n = 1'b1;
      repeat (4) @(negedge clk_sys);
   endtask : bus

   task automatic do_reset();
      @(negedge clk_sys);
      resetn = 1'b0;
      repeat (20) @(negedge clk_sys);
      resetn = 1'b1;
      @(negedge clk_sys);
   endtask : do_reset

   task automatic run_frame(input logic [7:0] ctl, input logic [7:0] cmd,
                            input logic [7:0] tx, input logic [7:0] rx,
                            input int nb);
      logic [7:0] rd, wd, got, mask;
      logic       par, ok, pen, even, two;
      mask = 8'hFF >> (8 - nb);
      pen = cmd[CMD_PAR_EN];
      even = cmd[CMD_PAR_EVEN];
      two = ctl[CTL_STOP2];
      bus(1'b0, RS_CONTROL, ctl, rd);
      bus(1'b0, RS_COMMAND, cmd, rd);
      bus(1'b1, RS_CONTROL, 8'h00, rd);
      chk(rd, ctl);
      bus(1'b1, RS_COMMAND, 8'h00, rd);
      chk(rd, cmd);
      fork
         bus(1'b0, RS_DATA, tx, wd);
         modem.send(rx, nb, pen, even, two);
         modem.recv(nb, pen, two, got, par, ok);
      join
      chk(got, tx & mask);
      if (pen) chk({7'h0, par}, {7'h0, ^(tx & mask) ^ ~even});
      chk({7'h0, ok}, 8'h01);
      // let the last stop bit finish before touching control again
      repeat (2080) @(negedge clk_sys);
      bus(1'b1, RS_DATA, 8'h00, rd);
      chk(rd, rx & mask);
      // clean frame: no parity or framing error, queue not full, nothing held
      bus(1'b1, RS_STATUS, 8'h00, rd);
      chk(rd, 8'h10);
   endtask : run_frame

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset_state();
      logic [7:0] rd;
      chk({7'h0, txd}, 8'h01);
      chk({7'h0, data_oe}, 8'h00);
      chk(rdata, 8'h00);
      bus(1'b1, RS_STATUS, 8'h00, rd);
      chk(rd, 8'h10);
   endtask : t_reset_state

   task automatic t_eight_none_one();
      run_frame(8'h00, 8'h00, 8'hA5, 8'h3C, 8);
   endtask : t_eight_none_one

   task automatic t_five_even_two();
      run_frame(8'hE0, 8'h60, 8'hE6, 8'h15, 5);
   endtask : t_five_even_two

   task automatic t_seven_odd_one();
      run_frame(8'h20, 8'h20, 8'hAA, 8'h41, 7);
   endtask : t_seven_odd_one

   task automatic t_six_none_one();
      run_frame(8'h40, 8'h00, 8'hD9, 8'h2E, 6);
   endtask : t_six_none_one

   // one byte moves to the shifter first, then eight fill the queue and
   // the ninth is dropped
   task automatic t_fifo_full();
      logic [7:0] rd;
      bus(1'b0, RS_DATA, 8'h00, rd);
      // wait past one oversample period so the shifter surely holds it
      repeat (200) @(negedge clk_sys);
      for (int i = 1; i < 10; i++) begin
         bus(1'b0, RS_DATA, 8'(i), rd);
      end
      bus(1'b1, RS_STATUS, 8'h00, rd);
      chk(rd & 8'h10, 8'h00);
      do_reset();
      chk({7'h0, txd}, 8'h01);
      bus(1'b1, RS_STATUS, 8'h00, rd);
      chk(rd, 8'h10);
   endtask : t_fifo_full

   // ****************************************************************
   // run control
   // ****************************************************************
   task automatic summarize();
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (20) @(negedge clk_sys);
      resetn = 1'b1;
      @(negedge clk_sys);
      t_reset_state();
      t_eight_none_one();
      t_five_even_two();
      t_seven_odd_one();
      t_six_none_one();
      t_fifo_full();
      summarize();
   end

   // about 95000 clocks; the four frames need some 85000
   initial begin
      #4750000;
      miscompares++;
      summarize();
   end
endmodule : uda_top_tb_top

`default_nettype wire
